// ===== hw/dsi_video_timing.v
// Video mode configuration registers and line/frame timing generator.
// Assumes an AXI4-Lite master on sys_clk and a lane byte clock pin sampled here.
// Functional notes
// (R1) Colour coding 0-2 are 16bpp variants, 3-4 18bpp variants, 5 is 24bpp.
// (R2) Loose-pack bit set sends 18-bit pixels loosely packed, else tightly.
// (R3) Software keeps pixels per packet a multiple of four for tight 18-bit.
// (R4) Blanking-line low-power commands only when within the outside-active byte budget.
// (R5) Software sets the outside-active budget to at least four bytes.
// (R6) Active-line low-power commands are limited to the inside-active byte budget.
// (R7) Pattern enable replaces pixels; mode picks bars or BER; orientation picks bar direction.
// (R8) Low-power command bit set allows command transmission only in low power.
// (R9) Frame acknowledge bit requests a turnaround acknowledge at each frame end.
// (R10) Six enables let the link drop to low power in their periods if time allows.
// (R11) Transfer type 00 sync pulses, 01 sync events, 1x burst.
// (R12) Each line carries the programmed number of chunks, video or null.
// (R13) Each null packet carries the programmed byte count.
// (R14) Horizontal sync lasts the programmed number of byte clock cycles.
// (R15) Horizontal back porch lasts the programmed number of byte clock cycles.
// (R16) Whole line lasts the programmed number of byte clock cycles.
// (R17) Vertical sync lasts the programmed number of lines.
// (R18) Vertical back and front porch each last their programmed number of lines.
// (R19) Vertical active lasts the programmed number of lines.
// (R20) Burst sends the whole active line as one packet, ignoring chunks and null size.
// (R21) Non-burst splits the active line into several packets, one buffered at a time.
// (R22) Null packets only when both null insertion and multi-packet division are on.
// (R23) Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`include "dsi_video_defines.vh"
module dsi_video_timing #(
	parameter ADDR_W = 12
) (
	input wire sys_clk,
	input wire rst_n,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire laneByteClk,
	input wire [23:0] pixIn,
	input wire cmdPending,
	input wire [7:0] cmdBytes,
	output reg [23:0] pixOut,
	output reg pktStart,
	output reg pktIsNull,
	output reg [16:0] pktBytes,
	output reg [1:0] vRegion,
	output wire [1:0] hPhase,
	output reg lpMode,
	output wire [7:0] lpCmdBudget,
	output wire lpCmdGrant,
	output wire hsCmdAllowed,
	output wire burstMode,
	output wire syncEvents,
	output wire loosePack,
	output reg [1:0] bytesPerPixel,
	output reg frameAckReq
);
	localparam NREG = 14;
	localparam IDX_MISS = 4'hf;

	reg [31:0] cfg [0:NREG-1];
	reg awHeld_q;
	reg wHeld_q;
	reg [ADDR_W-1:0] awAddr_q;
	reg [31:0] wData_q;
	reg [3:0] wStrb_q;
	wire byteTick;

	// Register index from byte address; miss for anything unmapped
	function [3:0] regIndex;
		input [ADDR_W-1:0] addr;
		begin
			case (addr[11:0])
				`OFF_PIXEL_FORMAT: regIndex = 4'h0;
				`OFF_LP_CMD_WINDOW: regIndex = 4'h1;
				`OFF_VIDEO_CFG: regIndex = 4'h2;
				`OFF_PIX_PER_PKT: regIndex = 4'h3;
				`OFF_CHUNKS: regIndex = 4'h4;
				`OFF_FILLER_BYTES: regIndex = 4'h5;
				`OFF_HSYNC: regIndex = 4'h6;
				`OFF_HBP: regIndex = 4'h7;
				`OFF_HLINE: regIndex = 4'h8;
				`OFF_VSYNC: regIndex = 4'h9;
				`OFF_VBP: regIndex = 4'ha;
				`OFF_VFP: regIndex = 4'hb;
				`OFF_VACT: regIndex = 4'hc;
				`OFF_PKT_OPTIONS: regIndex = 4'hd;
				`OFF_STATUS: regIndex = 4'he;
				default: regIndex = IDX_MISS;
			endcase
		end
	endfunction

	// Writable bits of each register
	function [31:0] regMask;
		input [3:0] idx;
		begin
			case (idx)
				4'h0: regMask = `MASK_PIXEL_FORMAT;
				4'h1: regMask = `MASK_LP_CMD_WINDOW;
				4'h2: regMask = `MASK_VIDEO_CFG;
				4'h3: regMask = `MASK_PIX_PER_PKT;
				4'h4, 4'h5: regMask = `MASK_13BIT;
				4'h6, 4'h7: regMask = `MASK_12BIT;
				4'h8: regMask = `MASK_HLINE;
				4'h9, 4'ha, 4'hb: regMask = `MASK_10BIT;
				4'hc: regMask = `MASK_VACT;
				4'hd: regMask = `MASK_PKT_OPTIONS;
				default: regMask = 32'h00000000;
			endcase
		end
	endfunction

	wire [3:0] wrIdx = regIndex(awAddr_q);
	wire [3:0] rdIdx = regIndex(s_axi_araddr);
	wire doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
	wire [31:0] strbMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};

	assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
	assign s_axi_wready = ~wHeld_q & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	// Write channel: address and data captured in either order, then one response
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= {ADDR_W{1'b0}};
			wData_q <= 32'h00000000;
			wStrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wrIdx == IDX_MISS) ? `RESP_SLVERR : `RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register array; only writable bits ever change
	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi = gi + 1) begin : gReg
			always @(posedge sys_clk) begin
				if (!rst_n) begin
					cfg[gi] <= `REG_RESET;
				end else if (doWrite && wrIdx == gi) begin
					cfg[gi] <= ((cfg[gi] & ~strbMask) | (wData_q & strbMask))
						& regMask(gi); // see (R23)
				end
			end
		end
	endgenerate

	// Field views
	wire [3:0] colorCode = cfg[0][3:0];
	wire [7:0] outsideBudget = cfg[1][23:16];
	wire [7:0] insideBudget = cfg[1][7:0];
	wire [31:0] vcfg = cfg[2];
	wire [13:0] pixPerPkt = cfg[3][13:0];
	wire [12:0] numChunks = cfg[4][12:0];
	wire [12:0] nullSize = cfg[5][12:0];
	wire [11:0] hsaTime = cfg[6][11:0];
	wire [11:0] hbpTime = cfg[7][11:0];
	wire [14:0] hlineTime = cfg[8][14:0];
	wire [9:0] vsaLines = cfg[9][9:0];
	wire [9:0] vbpLines = cfg[10][9:0];
	wire [9:0] vfpLines = cfg[11][9:0];
	wire [13:0] vactLines = cfg[12][13:0];
	wire multiPkt = cfg[13][`BIT_MULTI_PKT];
	wire nullIns = cfg[13][`BIT_NULL_PKT] & multiPkt; // see (R22)

	reg [14:0] hCnt_q;
	reg [13:0] vLine_q;
	reg chunkBusy_q;
	reg lineDone_q;
	reg [12:0] chunkIdx_q;
	reg [16:0] chunkLeft_q;
	reg [13:0] pixX_q;
	wire [31:0] statusWord = {vRegion, hPhase, lpMode, chunkBusy_q, 12'h000, vLine_q};

	// Read channel: data registered one cycle after the address is taken
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= (rdIdx == IDX_MISS) ? `RESP_SLVERR : `RESP_OKAY;
			if (rdIdx == 4'he) begin
				s_axi_rdata <= statusWord;
			end else if (rdIdx == IDX_MISS) begin
				s_axi_rdata <= 32'h00000000;
			end else begin
				s_axi_rdata <= cfg[rdIdx];
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Lane byte clock edges drive all horizontal counting
	link_edge_sync uByteSync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.linkClk(laneByteClk),
		.riseTick(byteTick)
	);

	// Mode decode and bytes per pixel
	assign burstMode = vcfg[1]; // see (R11)
	assign syncEvents = (vcfg[1:0] == 2'h1); // see (R11)
	assign loosePack = cfg[0][`BIT_LOOSE_PACK];
	reg [16:0] videoBytes;
	always @* begin
		case (colorCode)
			`CODE_16BPP_1, `CODE_16BPP_2, `CODE_16BPP_3: begin // see (R1)
				bytesPerPixel = 2'h2;
				videoBytes = {2'b00, pixPerPkt, 1'b0};
			end
			`CODE_18BPP_1, `CODE_18BPP_2: begin // see (R1)
				bytesPerPixel = 2'h3;
				if (loosePack) begin
					videoBytes = {2'b00, pixPerPkt, 1'b0} + {3'b000, pixPerPkt}; // see (R2)
				end else begin
					videoBytes = ({pixPerPkt, 3'b000} + {3'b000, pixPerPkt}) >> 2; // see (R2) (R3)
				end
			end
			default: begin // see (R1)
				bytesPerPixel = 2'h3;
				videoBytes = {2'b00, pixPerPkt, 1'b0} + {3'b000, pixPerPkt};
			end
		endcase
	end

	// Horizontal phase boundaries in byte clock cycles
	wire [14:0] hsaEnd = {3'b000, hsaTime}; // see (R14)
	wire [14:0] hbpEnd = hsaEnd + {3'b000, hbpTime}; // see (R15)
	wire lineEnd = (hCnt_q + 15'h0001 >= hlineTime); // see (R16)
	assign hPhase = (hCnt_q < hsaEnd) ? `HPH_SYNC :
		(hCnt_q < hbpEnd) ? `HPH_BACK :
		(vRegion == `VREG_ACTIVE && !lineDone_q) ? `HPH_ACTIVE : `HPH_FRONT;

	// Length of the current vertical region in lines
	reg [13:0] regionLen;
	always @* begin
		case (vRegion)
			`VREG_SYNC: regionLen = {4'h0, vsaLines}; // see (R17)
			`VREG_BACK: regionLen = {4'h0, vbpLines}; // see (R18)
			`VREG_ACTIVE: regionLen = vactLines; // see (R19)
			`VREG_FRONT: regionLen = {4'h0, vfpLines}; // see (R18)
			default: regionLen = 14'h0000;
		endcase
	end

	// Chunk plan: burst or undivided is one packet, divided non-burst follows chunk count
	wire [12:0] chunkTotal = (burstMode || !multiPkt || numChunks == 13'h0000) ?
		13'h0001 : numChunks; // see (R12) (R20) (R21)
	wire nextIdxNull = nullIns & ~burstMode & ~chunkIdx_q[0]; // see (R22)
	wire [16:0] nextChunkLen = nextIdxNull ? {4'h0, nullSize} : videoBytes; // see (R13)
	wire activeStart = (vRegion == `VREG_ACTIVE) && (hCnt_q == hbpEnd);

	// Line, frame and chunk sequencing on byte clock edges
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			hCnt_q <= 15'h0000;
			vLine_q <= 14'h0000;
			vRegion <= `VREG_SYNC;
			chunkBusy_q <= 1'b0;
			lineDone_q <= 1'b0;
			chunkIdx_q <= 13'h0000;
			chunkLeft_q <= 17'h00000;
			pixX_q <= 14'h0000;
			pktStart <= 1'b0;
			pktIsNull <= 1'b0;
			pktBytes <= 17'h00000;
			frameAckReq <= 1'b0;
		end else begin
			pktStart <= 1'b0;
			frameAckReq <= 1'b0;
			if (byteTick) begin
				hCnt_q <= lineEnd ? 15'h0000 : hCnt_q + 15'h0001; // see (R16)
				if (lineEnd) begin
					lineDone_q <= 1'b0;
					chunkBusy_q <= 1'b0;
					pixX_q <= 14'h0000;
					if (vLine_q + 14'h0001 >= regionLen) begin
						vLine_q <= 14'h0000;
						vRegion <= vRegion + 2'h1; // see (R17) (R18) (R19)
						frameAckReq <= (vRegion == `VREG_FRONT) & vcfg[`BIT_FRAME_ACK]; // see (R9)
					end else begin
						vLine_q <= vLine_q + 14'h0001;
					end
				end else if (activeStart) begin
					chunkBusy_q <= 1'b1; // see (R20) (R21)
					chunkIdx_q <= 13'h0000;
					chunkLeft_q <= videoBytes;
					pktStart <= 1'b1;
					pktIsNull <= 1'b0;
					pktBytes <= videoBytes;
				end else if (chunkBusy_q) begin
					if (!pktIsNull) begin
						pixX_q <= pixX_q + 14'h0001;
					end
					if (chunkLeft_q > 17'h00001) begin
						chunkLeft_q <= chunkLeft_q - 17'h00001;
					end else if (chunkIdx_q + 13'h0001 >= chunkTotal) begin
						chunkBusy_q <= 1'b0;
						lineDone_q <= 1'b1;
					end else begin
						chunkIdx_q <= chunkIdx_q + 13'h0001; // see (R12)
						chunkLeft_q <= nextChunkLen;
						pktStart <= 1'b1;
						pktIsNull <= nextIdxNull; // see (R22)
						pktBytes <= nextChunkLen; // see (R13)
					end
				end
			end
		end
	end

	// Low-power excursion: region enable plus enough cycles left
	wire [14:0] phaseEnd = (hPhase == `HPH_BACK) ? hbpEnd : hlineTime;
	wire timeAllows = (phaseEnd > hCnt_q) && ({1'b0, phaseEnd - hCnt_q} >= `LP_MIN_CYCLES);
	reg lpWanted;
	always @* begin
		case (vRegion)
			`VREG_SYNC: lpWanted = vcfg[`BIT_LP_VSYNC]; // see (R10)
			`VREG_BACK: lpWanted = vcfg[`BIT_LP_VBP]; // see (R10)
			`VREG_FRONT: lpWanted = vcfg[`BIT_LP_VFP]; // see (R10)
			`VREG_ACTIVE: lpWanted = vcfg[`BIT_LP_VACT] &&
				((hPhase == `HPH_BACK && vcfg[`BIT_LP_HBP]) ||
				(hPhase == `HPH_FRONT && vcfg[`BIT_LP_HFP])); // see (R10)
			default: lpWanted = 1'b0;
		endcase
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			lpMode <= 1'b0;
		end else begin
			lpMode <= lpWanted & timeAllows & ~chunkBusy_q; // see (R10)
		end
	end

	// Command window: budget by region, commands only in low power if asked
	assign lpCmdBudget = (vRegion == `VREG_ACTIVE) ? insideBudget : outsideBudget; // see (R4) (R6)
	assign lpCmdGrant = cmdPending && lpMode && (cmdBytes <= lpCmdBudget); // see (R4) (R6)
	assign hsCmdAllowed = ~vcfg[`BIT_LP_CMD_ONLY] & ~chunkBusy_q; // see (R8)

	// Pixel source: pattern generator or the input stream
	wire [23:0] patPixel;
	test_pattern_gen uPattern (
		.pixelX(pixX_q),
		.lineY(vLine_q),
		.berMode(vcfg[`BIT_VPG_MODE]),
		.horizBars(vcfg[`BIT_VPG_ORIENT] & ~vcfg[`BIT_VPG_MODE]),
		.patPixel(patPixel)
	);

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			pixOut <= 24'h000000;
		end else begin
			pixOut <= vcfg[`BIT_VPG_EN] ? patPixel : pixIn; // see (R7)
		end
	end

endmodule // dsi_video_timing

// ===== hw/dsi_video_defines.vh
// Offsets, field positions, reset values and codes of the video timing block.
// Included by every design file; definitions only.
`ifndef DSI_VIDEO_DEFINES_VH
`define DSI_VIDEO_DEFINES_VH
// Register byte offsets
`define OFF_PIXEL_FORMAT 12'h110
`define OFF_LP_CMD_WINDOW 12'h118
`define OFF_VIDEO_CFG 12'h138
`define OFF_PIX_PER_PKT 12'h13c
`define OFF_CHUNKS 12'h140
`define OFF_FILLER_BYTES 12'h144
`define OFF_HSYNC 12'h148
`define OFF_HBP 12'h14c
`define OFF_HLINE 12'h150
`define OFF_VSYNC 12'h154
`define OFF_VBP 12'h158
`define OFF_VFP 12'h15c
`define OFF_VACT 12'h160
`define OFF_PKT_OPTIONS 12'h164
`define OFF_STATUS 12'h168
// Writable-bit masks; all other bits are reserved
`define MASK_PIXEL_FORMAT 32'h0000010f
`define MASK_LP_CMD_WINDOW 32'h00ff00ff
`define MASK_VIDEO_CFG 32'h0111ff03
`define MASK_PIX_PER_PKT 32'h00003fff
`define MASK_13BIT 32'h00001fff
`define MASK_12BIT 32'h00000fff
`define MASK_HLINE 32'h00007fff
`define MASK_10BIT 32'h000003ff
`define MASK_VACT 32'h00003fff
`define MASK_PKT_OPTIONS 32'h00000003
`define REG_RESET 32'h00000000
// Field positions
`define BIT_LOOSE_PACK 8
`define BIT_VPG_ORIENT 24
`define BIT_VPG_MODE 20
`define BIT_VPG_EN 16
`define BIT_LP_CMD_ONLY 15
`define BIT_FRAME_ACK 14
`define BIT_LP_HFP 13
`define BIT_LP_HBP 12
`define BIT_LP_VACT 11
`define BIT_LP_VFP 10
`define BIT_LP_VBP 9
`define BIT_LP_VSYNC 8
`define BIT_MULTI_PKT 0
`define BIT_NULL_PKT 1
// Colour codings
`define CODE_16BPP_1 4'h0
`define CODE_16BPP_2 4'h1
`define CODE_16BPP_3 4'h2
`define CODE_18BPP_1 4'h3
`define CODE_18BPP_2 4'h4
`define CODE_24BPP 4'h5
// Vertical regions and horizontal phases
`define VREG_SYNC 2'h0
`define VREG_BACK 2'h1
`define VREG_ACTIVE 2'h2
`define VREG_FRONT 2'h3
`define HPH_SYNC 2'h0
`define HPH_BACK 2'h1
`define HPH_ACTIVE 2'h2
`define HPH_FRONT 2'h3
// Least byte-clock cycles left in a period for a low-power excursion
`define LP_MIN_CYCLES 16'h0010
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== hw/link_edge_sync.v
// Samples the lane byte clock pin with the system clock and marks its rising edges.
// Assumes the sampled clock is well below half the system clock rate.
`timescale 1ns/1ps
`include "dsi_video_defines.vh"
module link_edge_sync (
	input wire sys_clk,
	input wire rst_n,
	input wire linkClk,
	output wire riseTick
);
	reg sync1_q;
	reg sync2_q;
	reg prev_q;

	// Two-flop synchroniser, then one history flop for the edge
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			sync1_q <= linkClk;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	assign riseTick = sync2_q & ~prev_q; // One system cycle per byte clock rising edge
endmodule // link_edge_sync

// ===== hw/test_pattern_gen.v
// Built-in test pattern: colour bars or a bit-error pattern.
// Assumes pixel column and line indices are supplied by the timing logic.
`timescale 1ns/1ps
`include "dsi_video_defines.vh"
module test_pattern_gen (
	input wire [13:0] pixelX,
	input wire [13:0] lineY,
	input wire berMode,
	input wire horizBars,
	output reg [23:0] patPixel
);
	reg [2:0] barIdx;

	// Eight bars; BER pattern alternates columns only
	always @* begin
		barIdx = horizBars ? lineY[6:4] : pixelX[6:4];
		if (berMode) begin
			patPixel = pixelX[0] ? 24'hffffff : 24'h000000; // see (R7)
		end else begin
			patPixel = {{8{~barIdx[1]}}, {8{~barIdx[2]}}, {8{~barIdx[0]}}}; // see (R7)
		end
	end
endmodule // test_pattern_gen

// ===== verif/dsi_video_timing_asserts.sv
// Checker for the video timing block: register bus handshakes, chunk and frame timing.
// Assumes it is bound to dsi_video_timing and sees only that module's ports.
`timescale 1ns/1ps
`include "dsi_video_defines.vh"
module dsi_video_timing_asserts (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic pktStart,
	input wire logic pktIsNull,
	input wire logic [1:0] vRegion,
	input wire logic burstMode,
	input wire logic lpMode,
	input wire logic lpCmdGrant,
	input wire logic cmdPending,
	input wire logic [7:0] cmdBytes,
	input wire logic [7:0] lpCmdBudget,
	input wire logic frameAckReq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Responses stay put until the master takes them
	sequence bHeld;
		s_axi_bvalid && $stable(s_axi_bresp);
	endsequence
	sequence rHeld;
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endsequence
	wresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> bHeld)
		else $error("write response changed before handshake");
	rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> rHeld)
		else $error("read response changed before handshake");
	write_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	read_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	chunk_pulse_a: assert property (pktStart |=> !pktStart)
		else $error("chunk start longer than one cycle");
	region_order_a: assert property (
		$changed(vRegion) |-> vRegion == $past(vRegion) + 2'h1)
		else $error("vertical region out of order");
	video_active_a: assert property (
		pktStart && !pktIsNull |-> vRegion == `VREG_ACTIVE)
		else $error("video chunk outside active lines");
	null_burst_a: assert property (pktStart && pktIsNull |-> !burstMode)
		else $error("null chunk in burst mode");
	grant_budget_a: assert property (
		lpCmdGrant |-> lpMode && cmdPending && cmdBytes <= lpCmdBudget)
		else $error("command granted beyond budget");
	ack_pulse_a: assert property (frameAckReq |=> !frameAckReq [*8])
		else $error("frame acknowledge request repeated");
endmodule // dsi_video_timing_asserts

bind dsi_video_timing dsi_video_timing_asserts i_dsi_video_timing_asserts (
	.sys_clk, .rst_n, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.s_axi_rresp, .pktStart, .pktIsNull, .vRegion, .burstMode, .lpMode, .lpCmdGrant,
	.cmdPending, .cmdBytes, .lpCmdBudget, .frameAckReq
);

// ===== verif/display_link_model.sv
// Far side of the video link: byte clock source, pixel and command source, frame statistics.
// Assumes the bench clears the statistics at a frame boundary and reads them hierarchically.
`timescale 1ns/1ps
`include "dsi_video_defines.vh"
module display_link_model (
	input wire logic sys_clk,
	input wire logic clr,
	input wire logic pktStart,
	input wire logic pktIsNull,
	input wire logic [16:0] pktBytes,
	input wire logic [1:0] vRegion,
	input wire logic [1:0] hPhase,
	input wire logic lpMode,
	input wire logic lpCmdGrant,
	input wire logic frameAckReq,
	output logic laneByteClk,
	output logic [23:0] pixIn,
	output logic cmdPending,
	output logic [7:0] cmdBytes
);
	int rc[4];
	int hs, hb, vids, nulls, acks, lps, grants;
	logic [16:0] vb, nb;
	// Byte clock of 160 ns, phase unrelated to the system clock
	initial begin
		laneByteClk = 1'b0;
		#37;
		forever #80 laneByteClk = ~laneByteClk;
	end
	// Steady pixel and a pending four-byte command
	assign pixIn = 24'h5a3c96;
	assign cmdPending = 1'b1;
	assign cmdBytes = 8'h04;
	// Cycles per region, sync and back porch phase cycles, chunk counts and sizes
	always @(posedge sys_clk) begin
		if (clr) begin
			rc <= '{0, 0, 0, 0};
			{hs, hb, vids, nulls, acks, lps, grants} <= '0;
		end else begin
			rc[vRegion] <= rc[vRegion] + 1;
			hs <= hs + int'(hPhase == `HPH_SYNC);
			hb <= hb + int'(hPhase == `HPH_BACK);
			acks <= acks + int'(frameAckReq);
			lps <= lps + int'(lpMode);
			grants <= grants + int'(lpCmdGrant);
			if (pktStart && pktIsNull) begin
				nulls <= nulls + 1;
				nb <= pktBytes;
			end
			if (pktStart && !pktIsNull) begin
				vids <= vids + 1;
				vb <= pktBytes;
			end
		end
	end
endmodule // display_link_model

// ===== verif/dsi_video_timing_tb.sv
// Self-checking bench: register map, decodes, pattern source and frame timing.
// Assumes the link model supplies the byte clock and pixel source.
`timescale 1ns/1ps
`include "dsi_video_defines.vh"
module dsi_video_timing_tb;
	localparam int LIMIT = 60000;
	localparam int LN = 800;
	localparam logic [11:0] OFFS [14] = '{`OFF_PIXEL_FORMAT, `OFF_PIX_PER_PKT, `OFF_CHUNKS,
		`OFF_FILLER_BYTES, `OFF_HSYNC, `OFF_HBP, `OFF_HLINE, `OFF_VSYNC, `OFF_VBP,
		`OFF_VFP, `OFF_VACT, `OFF_PKT_OPTIONS, `OFF_LP_CMD_WINDOW, `OFF_VIDEO_CFG};
	localparam logic [31:0] MASKS [14] = '{`MASK_PIXEL_FORMAT, `MASK_PIX_PER_PKT,
		`MASK_13BIT, `MASK_13BIT, `MASK_12BIT, `MASK_12BIT, `MASK_HLINE, `MASK_10BIT,
		`MASK_10BIT, `MASK_10BIT, `MASK_VACT, `MASK_PKT_OPTIONS, `MASK_LP_CMD_WINDOW,
		`MASK_VIDEO_CFG};
	// Timing setup in the same order as OFFS
	localparam logic [31:0] SETUP [14] = '{32'h3, 32'h4, 32'h2, 32'h5, 32'h2, 32'h3,
		32'h28, 32'h1, 32'h1, 32'h1, 32'h2, 32'h3, 32'h00200010, 32'hff00};
	logic sys_clk = 0;
	logic rst_n = 0;
	logic clr = 0;
	logic [11:0] s_axi_awaddr = 0;
	logic [11:0] s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp, vRegion, hPhase, bytesPerPixel;
	wire [31:0] s_axi_rdata;
	wire laneByteClk, cmdPending, pktStart, pktIsNull, lpMode, lpCmdGrant, hsCmdAllowed;
	wire burstMode, syncEvents, loosePack, frameAckReq;
	wire [23:0] pixIn, pixOut;
	wire [7:0] cmdBytes, lpCmdBudget;
	wire [16:0] pktBytes;
	int miscompares = 0;
	int check_count = 0;
	int cycles = 0;

	dsi_video_timing i_dsi_video_timing (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.laneByteClk, .pixIn, .cmdPending, .cmdBytes, .pixOut, .pktStart, .pktIsNull,
		.pktBytes, .vRegion, .hPhase, .lpMode, .lpCmdBudget, .lpCmdGrant, .hsCmdAllowed,
		.burstMode, .syncEvents, .loosePack, .bytesPerPixel, .frameAckReq);
	display_link_model i_display_link_model (.sys_clk, .clr, .pktStart, .pktIsNull,
		.pktBytes, .vRegion, .hPhase, .lpMode, .lpCmdGrant, .frameAckReq, .laneByteClk,
		.pixIn, .cmdPending, .cmdBytes);

	// 125 MHz clock and a cycle ceiling against hangs
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			miscompares++;
			results();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic bit near(int a, int e);
		return a >= e - 6 && a <= e + 6;
	endfunction

	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw, w;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		aw = 1;
		w = 1;
		while (aw || w) begin
			@(posedge sys_clk);
			if (aw && s_axi_awready) begin
				aw = 0;
				s_axi_awvalid <= 0;
			end
			if (w && s_axi_wready) begin
				w = 0;
				s_axi_wvalid <= 0;
			end
		end
		do @(posedge sys_clk); while (!s_axi_bvalid);
		s_axi_bready <= 1;
		@(posedge sys_clk);
		r = s_axi_bresp;
		s_axi_bready <= 0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1;
		@(posedge sys_clk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask

	// Waits for the next entry into vertical region v
	task automatic enter(input logic [1:0] v);
		do @(negedge sys_clk); while (vRegion === v);
		do @(negedge sys_clk); while (vRegion !== v);
	endtask

	// Gathers one frame from active start to active start and checks it
	task automatic frame(input int v, input int n, input int a);
		enter(`VREG_ACTIVE);
		@(posedge sys_clk) clr <= 1;
		@(posedge sys_clk) clr <= 0;
		enter(`VREG_ACTIVE);
		for (int k = 0; k < 4; k++)
			chk(near(i_display_link_model.rc[k], (k == 2 ? 2 : 1) * LN), 1);
		chk(near(i_display_link_model.hs, 200), 1);
		chk(near(i_display_link_model.hb, 300), 1);
		chk(i_display_link_model.vids, v);
		chk(i_display_link_model.nulls, n);
		chk(i_display_link_model.acks, a);
		if (n > 0) begin
			chk(i_display_link_model.nb, 5);
			chk(i_display_link_model.vb, 9);
		end
	endtask

	task automatic results;
		$display("checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Main sequence
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1;
		for (int i = 0; i < 14; i++) begin
			rd(OFFS[i], d, r);
			chk(d, `REG_RESET);
			wr(OFFS[i], 32'hffffffff, r);
			rd(OFFS[i], d, r);
			chk(d, MASKS[i]);
			wr(OFFS[i], 32'h0, r);
		end
		rd(12'h200, d, r);
		chk({r, d[29:0]}, {`RESP_SLVERR, 30'h0});
		wr(12'h200, 32'hffffffff, r);
		chk(r, `RESP_SLVERR);
		$display("register map done");
		for (int i = 0; i < 4; i++) begin
			wr(`OFF_VIDEO_CFG, i, r);
			@(negedge sys_clk);
			chk({burstMode, syncEvents}, {i[1], !i[1] && i[0]});
		end
		for (int i = 0; i < 6; i++) begin
			wr(`OFF_PIXEL_FORMAT, 32'h100 | i, r);
			@(negedge sys_clk);
			chk({loosePack, bytesPerPixel}, {1'b1, (i < 3) ? 2'h2 : 2'h3});
		end
		wr(`OFF_PIXEL_FORMAT, 32'h5, r);
		@(negedge sys_clk);
		chk(loosePack, 0);
		wr(`OFF_VIDEO_CFG, 32'h0, r);
		repeat (2) @(negedge sys_clk);
		chk(pixOut, pixIn);
		for (int i = 0; i < 4; i++) begin
			wr(`OFF_VIDEO_CFG, 32'h10000 | (i[0] << 20) | (i[1] << 24), r);
			repeat (2) @(negedge sys_clk);
			chk(pixOut !== pixIn, 1);
		end
		$display("decodes done");
		for (int i = 0; i < 14; i++)
			wr(OFFS[i], SETUP[i], r);
		frame(2, 2, 1);
		chk(i_display_link_model.lps > 0, 1);
		chk(i_display_link_model.grants > 0, 1);
		chk(hsCmdAllowed, 0);
		enter(`VREG_ACTIVE);
		chk(lpCmdBudget, 8'h10);
		enter(`VREG_SYNC);
		chk(lpCmdBudget, 8'h20);
		$display("chunked frame done");
		wr(`OFF_PKT_OPTIONS, 32'h2, r);
		wr(`OFF_VIDEO_CFG, 32'h0, r);
		frame(2, 0, 0);
		chk(i_display_link_model.lps, 0);
		chk(i_display_link_model.grants, 0);
		chk(hsCmdAllowed, 1);
		$display("single packet frame done");
		wr(`OFF_PKT_OPTIONS, 32'h3, r);
		wr(`OFF_VIDEO_CFG, 32'h2, r);
		frame(2, 0, 0);
		$display("burst frame done");
		results();
	end
endmodule // dsi_video_timing_tb
